// ==== design/ljq_bit_mem.sv ====
// Jitter attenuator data store, never cleared
`timescale 1ns/100ps
module ljq_bit_mem #(
    parameter int DEPTH = 128,
    parameter int AW    = 7
) (
    input  wire logic          sys_clk_i,
    input  wire logic          wr_en_i,
    input  wire logic [AW-1:0] wr_addr_i,
    input  wire logic          wr_data_i,
    input  wire logic          rd_en_i,
    input  wire logic [AW-1:0] rd_addr_i,
    output logic               rd_data_o
);
    // No reset here: a clear leaves stored bits in place
    logic mem_r [DEPTH];

    always_ff @(posedge sys_clk_i) begin
        if (wr_en_i) begin
            mem_r[wr_addr_i] <= wr_data_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rd_en_i) begin
            rd_data_o <= mem_r[rd_addr_i];
        end
    end
endmodule // ljq_bit_mem

// ==== design/ljq_eq_step.sv ====
// Automatic equalizer level stepper driven by peak count thresholds
`timescale 1ns/100ps
module ljq_eq_step #(
    parameter int LEVEL_W = 4
) (
    input  wire logic               sys_clk_i,
    input  wire logic               reset_i,
    input  wire logic               auto_eq_i,
    input  wire logic               peak_valid_i,
    input  wire logic [7:0]         peak_count_i,
    input  wire logic [7:0]         upper_limit_i,
    input  wire logic [7:0]         lower_limit_i,
    output logic [LEVEL_W-1:0]      eq_level_o
);
    import ljq_pkg::*;

    localparam logic [LEVEL_W-1:0] LEVEL_TOP = {LEVEL_W{1'b1}};

    logic [LEVEL_W-1:0] level_r;
    logic [LEVEL_W-1:0] level_nxt;
    wire                sample_ok  = auto_eq_i && peak_valid_i;                  // [RULE9]
    wire                too_high   = peak_count_i > upper_limit_i;
    wire                too_low    = peak_count_i < lower_limit_i;
    wire                step_down  = sample_ok && too_high && (level_r != '0);  // [RULE7]
    wire                step_up    = sample_ok && !too_high && too_low
                                     && (level_r != LEVEL_TOP);                  // [RULE8]

    // Inside the band, or when a step would pass zero or LEVEL_TOP, level holds
    assign level_nxt = step_down ? level_r - 1'b1 :
                       step_up   ? level_r + 1'b1 : level_r;                     // [RULE13]

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            level_r <= '0;
        end else begin
            level_r <= level_nxt;
        end
    end

    assign eq_level_o = level_r;

    property p_step_down;
        @(posedge sys_clk_i) disable iff (reset_i)
        (auto_eq_i && peak_valid_i && peak_count_i > upper_limit_i && level_r != '0)
        |=> (level_r == $past(level_r) - 1'b1);
    endproperty
    a_step_down: assert property (p_step_down) else $error("level did not drop"); // [RULE7]

    property p_step_up;
        @(posedge sys_clk_i) disable iff (reset_i)
        (auto_eq_i && peak_valid_i && peak_count_i < lower_limit_i
         && peak_count_i <= upper_limit_i && level_r != LEVEL_TOP)
        |=> (level_r == $past(level_r) + 1'b1);
    endproperty
    a_step_up: assert property (p_step_up) else $error("level did not rise"); // [RULE8]

    property p_band_hold;
        @(posedge sys_clk_i) disable iff (reset_i)
        (peak_valid_i && peak_count_i >= lower_limit_i && peak_count_i <= upper_limit_i)
        |=> $stable(level_r);
    endproperty
    a_band_hold: assert property (p_band_hold) else $error("level moved in band"); // [RULE13]

    property p_manual_hold;
        @(posedge sys_clk_i) disable iff (reset_i)
        !auto_eq_i |=> $stable(level_r);
    endproperty
    a_manual_hold: assert property (p_manual_hold) else $error("level moved, auto off"); // [RULE9]

    c_step_down: cover property (@(posedge sys_clk_i) disable iff (reset_i) step_down);
    c_step_up: cover property (@(posedge sys_clk_i) disable iff (reset_i) step_up);
endmodule // ljq_eq_step

// ==== design/ljq_top.sv ====
// Jitter attenuator FIFO control and equalizer threshold registers
//
// Behaviour
// [RULE1] Toggling the centering bit re-centers the attenuator FIFO read pointer.
// [RULE2] Output jitter may rise temporarily while a centering is in progress.
// [RULE3] Depth equals sixteen times depth code plus one: 16 up to 128.
// [RULE4] Writing clear as one resets attenuator pointers and status.
// [RULE5] After clear status shows empty; stored data bits stay untouched.
// [RULE6] Centering, depth and clear act only in inverse-mux mode.
// [RULE7] Peak count above upper limit selects a lower equalization level.
// [RULE8] Peak count below lower limit selects a higher equalization level.
// [RULE9] Both limits matter only when automatic equalization is selected.
// [RULE10] Software should program the upper limit with 10111011.
// [RULE11] Software should program the lower limit with 00110000.
// [RULE12] Inverse-mux mode follows the mode bit of the serial configuration.
// [RULE13] Peak count within the limits inclusive keeps the level unchanged.
// [RULE14] Either edge of the centering bit versus its last write triggers centering.
`timescale 1ns/100ps
module ljq_top #(
    parameter int LEVEL_W = 4
) (
    input  wire logic                  sys_clk_i,
    input  wire logic                  reset_i,
    input  wire ljq_pkg::ljq_cpu_req_t cpu_req_i,
    output logic [7:0]                 cpu_rdata_o,
    input  wire logic                  ima_mode_i,
    input  wire logic                  auto_eq_i,
    input  wire logic                  peak_valid_i,
    input  wire logic [7:0]            peak_count_i,
    output logic [LEVEL_W-1:0]         eq_level_o,
    input  wire logic                  att_wr_valid_i,
    input  wire logic                  att_wr_data_i,
    input  wire logic                  att_rd_req_i,
    output logic                       att_rd_valid_o,
    output logic                       att_rd_data_o,
    output logic                       att_center_o,
    output ljq_pkg::ljq_fifo_stat_t    att_stat_o
);
    import ljq_pkg::*;

    // Depth in bits for a depth code
    function automatic logic [7:0] depth_of(input logic [DEPTH_W-1:0] code);
        depth_of = DEPTH_STEP * ({5'h00, code} + 8'h01);
    endfunction

    // Pointer advance with wrap at the active depth
    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p,
                                                 input logic [7:0]       d);
        ptr_inc = (({1'b0, p} + 8'h01) >= d) ? '0 : p + 1'b1;
    endfunction

    // Pointer step back by half the depth, modulo depth
    function automatic logic [PTR_W-1:0] ptr_back_half(input logic [PTR_W-1:0] p,
                                                       input logic [7:0]       d);
        logic [7:0] half;
        logic [7:0] sum;
        half = {1'b0, d[7:1]};
        sum  = ({1'b0, p} >= half) ? ({1'b0, p} - half) : ({1'b0, p} + d - half);
        ptr_back_half = sum[PTR_W-1:0];
    endfunction

    // Register state
    logic [7:0]         att_ctrl_r;
    logic [7:0]         eq_upper_limit_r;
    logic [7:0]         eq_lower_limit_r;
    logic [DEPTH_W-1:0] depth_code_r;
    logic [7:0]         cpu_rdata_r;

    // Attenuator FIFO state
    logic [PTR_W-1:0]   wr_ptr_r;
    logic [PTR_W-1:0]   rd_ptr_r;
    logic [7:0]         level_r;
    logic [PTR_W-1:0]   wr_ptr_nxt;
    logic [PTR_W-1:0]   rd_ptr_nxt;
    logic [7:0]         level_nxt;
    logic               rd_valid_r;
    logic               center_r;
    logic               mem_rd_data;

    // Register decode
    wire        wr_ctrl   = cpu_req_i.wr && (cpu_req_i.addr == ADDR_ATT_CTRL);
    wire        wr_upper  = cpu_req_i.wr && (cpu_req_i.addr == ADDR_EQ_HIGH);
    wire        wr_lower  = cpu_req_i.wr && (cpu_req_i.addr == ADDR_EQ_LOW);
    wire        ima_on    = ima_mode_i;                                          // [RULE12]
    wire        ctrl_take = wr_ctrl && ima_on;                                   // [RULE6]

    wire              new_center = cpu_req_i.wdata[CENTER_BIT];
    wire [DEPTH_W-1:0] new_depth = cpu_req_i.wdata[DEPTH_LSB +: DEPTH_W];
    wire              clear_req  = ctrl_take && cpu_req_i.wdata[CLEAR_BIT];      // [RULE4]
    wire              depth_chg  = ctrl_take && (new_depth != depth_code_r);     // [RULE3]
    wire              center_req = ctrl_take
                                   && (new_center != att_ctrl_r[CENTER_BIT]);    // [RULE14]

    // Active depth, taken from the last code accepted in inverse-mux mode
    wire [7:0]  depth_val = depth_of(depth_code_r);                              // [RULE3]
    wire [7:0]  half_val  = {1'b0, depth_val[7:1]};
    wire        fifo_empty = (level_r == 8'h00);
    wire        fifo_full  = (level_r == depth_val);
    // Full FIFO drops incoming bits rather than corrupting the read side
    wire        do_write  = att_wr_valid_i && !fifo_full;
    wire        do_read   = att_rd_req_i && !fifo_empty;

    // Pointer and level update; clear or depth change beats centering
    always_comb begin
        wr_ptr_nxt = wr_ptr_r;
        rd_ptr_nxt = rd_ptr_r;
        level_nxt  = level_r;
        if (clear_req || depth_chg) begin
            // Depth change restarts the pointers so they never pass the new wrap
            wr_ptr_nxt = '0;                                                     // [RULE4]
            rd_ptr_nxt = '0;
            level_nxt  = 8'h00;                                                  // [RULE5]
        end else if (center_req) begin
            rd_ptr_nxt = ptr_back_half(wr_ptr_r, depth_val);                     // [RULE1]
            level_nxt  = half_val;
        end else begin
            if (do_write) begin
                wr_ptr_nxt = ptr_inc(wr_ptr_r, depth_val);
            end
            if (do_read) begin
                rd_ptr_nxt = ptr_inc(rd_ptr_r, depth_val);
            end
            level_nxt = level_r + {7'h00, do_write} - {7'h00, do_read};
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            level_r  <= 8'h00;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            level_r  <= level_nxt;
        end
    end

    // Centering slips the read phase; a short burst of output jitter is expected
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            center_r   <= 1'b0;
            rd_valid_r <= 1'b0;
        end else begin
            center_r   <= center_req && !clear_req && !depth_chg;                // [RULE2]
            rd_valid_r <= do_read && !clear_req && !depth_chg && !center_req;
        end
    end

    // Control word only changes on writes accepted in inverse-mux mode
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            att_ctrl_r   <= ATT_CTRL_RST;
            depth_code_r <= ATT_CTRL_RST[DEPTH_LSB +: DEPTH_W];
        end else begin
            if (ctrl_take) begin
                att_ctrl_r <= cpu_req_i.wdata & ATT_CTRL_MASK;                   // [RULE6]
            end
            if (ctrl_take) begin
                depth_code_r <= new_depth;                                       // [RULE3]
            end
        end
    end

    // Thresholds stored always, used only by the stepper when automatic
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            eq_upper_limit_r <= EQ_HIGH_RST;                                     // [RULE10]
            eq_lower_limit_r <= EQ_LOW_RST;                                      // [RULE11]
        end else begin
            if (wr_upper) begin
                eq_upper_limit_r <= cpu_req_i.wdata;
            end
            if (wr_lower) begin
                eq_lower_limit_r <= cpu_req_i.wdata;
            end
        end
    end

    // Read mux, unmapped addresses read zero
    wire [7:0] stat_word = {fifo_empty, fifo_full, 6'h00};
    wire [7:0] rd_mux =
        (cpu_req_i.addr == ADDR_ATT_CTRL)   ? att_ctrl_r :
        (cpu_req_i.addr == ADDR_EQ_HIGH)    ? eq_upper_limit_r :
        (cpu_req_i.addr == ADDR_EQ_LOW)     ? eq_lower_limit_r :
        (cpu_req_i.addr == ADDR_ATT_STATUS) ? stat_word : 8'h00;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            cpu_rdata_r <= 8'h00;
        end else if (cpu_req_i.rd) begin
            cpu_rdata_r <= rd_mux;
        end
    end

    ljq_bit_mem #(
        .DEPTH (DEPTH_MAX),
        .AW    (PTR_W)
    ) u_mem (
        .sys_clk_i (sys_clk_i),
        .wr_en_i   (do_write && !clear_req && !depth_chg && !center_req),
        .wr_addr_i (wr_ptr_r),
        .wr_data_i (att_wr_data_i),
        .rd_en_i   (do_read),
        .rd_addr_i (rd_ptr_r),
        .rd_data_o (mem_rd_data)
    );

    ljq_eq_step #(
        .LEVEL_W (LEVEL_W)
    ) u_eq (
        .sys_clk_i     (sys_clk_i),
        .reset_i       (reset_i),
        .auto_eq_i     (auto_eq_i),                                              // [RULE9]
        .peak_valid_i  (peak_valid_i),
        .peak_count_i  (peak_count_i),
        .upper_limit_i (eq_upper_limit_r),
        .lower_limit_i (eq_lower_limit_r),
        .eq_level_o    (eq_level_o)
    );

    assign cpu_rdata_o      = cpu_rdata_r;
    assign att_rd_valid_o   = rd_valid_r;
    assign att_rd_data_o    = rd_valid_r ? mem_rd_data : 1'b0;
    assign att_center_o     = center_r;
    assign att_stat_o.empty = fifo_empty;
    assign att_stat_o.full  = fifo_full;
    assign att_stat_o.level = level_r;

    property p_center;
        @(posedge sys_clk_i) disable iff (reset_i)
        (center_req && !clear_req && !depth_chg)
        |=> (level_r == half_val) && att_center_o
            && (rd_ptr_r == ptr_back_half(wr_ptr_r, depth_val));
    endproperty
    a_center: assert property (p_center) else $error("centering not applied"); // [RULE1]

    property p_toggle_any;
        @(posedge sys_clk_i) disable iff (reset_i)
        (ima_on && wr_ctrl && (cpu_req_i.wdata[CENTER_BIT] != att_ctrl_r[CENTER_BIT]))
        |=> (att_center_o || fifo_empty);
    endproperty
    a_toggle_any: assert property (p_toggle_any) else $error("toggle missed"); // [RULE14]

    property p_clear;
        @(posedge sys_clk_i) disable iff (reset_i)
        clear_req |=> fifo_empty && att_stat_o.empty && (rd_ptr_r == '0) && (wr_ptr_r == '0);
    endproperty
    a_clear: assert property (p_clear) else $error("clear not applied"); // [RULE4]

    // A centering write right after the clear legally refills half the depth
    property p_clear_empty_holds;
        @(posedge sys_clk_i) disable iff (reset_i)
        (clear_req && !att_wr_valid_i) ##1 (!att_wr_valid_i && !ctrl_take) |=> fifo_empty;
    endproperty
    a_clear_empty_holds: assert property (p_clear_empty_holds) else $error("not empty"); // [RULE5]

    property p_no_ima;
        @(posedge sys_clk_i) disable iff (reset_i)
        (wr_ctrl && !ima_on) |=> $stable(depth_code_r) && $stable(att_ctrl_r) && !att_center_o;
    endproperty
    a_no_ima: assert property (p_no_ima) else $error("control acted outside mode"); // [RULE6]

    property p_depth;
        @(posedge sys_clk_i) disable iff (reset_i)
        ctrl_take |=> (depth_val == DEPTH_STEP * ({5'h00, $past(new_depth)} + 8'h01));
    endproperty
    a_depth: assert property (p_depth) else $error("depth code not applied"); // [RULE3]

    property p_level_bound;
        @(posedge sys_clk_i) disable iff (reset_i)
        level_r <= depth_val;
    endproperty
    a_level_bound: assert property (p_level_bound) else $error("fill above depth"); // [RULE3]

    property p_mode_gate;
        @(posedge sys_clk_i) disable iff (reset_i)
        !ima_mode_i |-> !ctrl_take && !clear_req && !center_req;
    endproperty
    a_mode_gate: assert property (p_mode_gate) else $error("mode gate open"); // [RULE12]

    c_center: cover property (@(posedge sys_clk_i) disable iff (reset_i) center_req);
    c_clear: cover property (@(posedge sys_clk_i) disable iff (reset_i) clear_req);
    c_full: cover property (@(posedge sys_clk_i) disable iff (reset_i) fifo_full);
endmodule // ljq_top

// ==== include/ljq_pkg.sv ====
// Shared constants and carriers for the line-interface jitter and equalizer control
package ljq_pkg;
    // Register byte addresses on the microprocessor port
    localparam logic [7:0] ADDR_ATT_CTRL   = 8'h12;
    localparam logic [7:0] ADDR_EQ_HIGH    = 8'h13;
    localparam logic [7:0] ADDR_EQ_LOW     = 8'h16;
    localparam logic [7:0] ADDR_ATT_STATUS = 8'h1A;

    // Control word fields
    localparam int CENTER_BIT = 6;
    localparam int DEPTH_LSB  = 3;
    localparam int DEPTH_W    = 3;
    localparam int CLEAR_BIT  = 2;
    localparam logic [7:0] ATT_CTRL_MASK = 8'h7C;

    // Status word fields
    localparam int STAT_EMPTY_BIT = 7;
    localparam int STAT_FULL_BIT  = 6;

    // Reset values
    localparam logic [7:0] ATT_CTRL_RST = 8'h00;
    localparam logic [7:0] EQ_HIGH_RST  = 8'hBB;
    localparam logic [7:0] EQ_LOW_RST   = 8'h30;

    // Depth granularity and largest depth
    localparam logic [7:0] DEPTH_STEP = 8'h10;
    localparam int         DEPTH_MAX  = 128;
    localparam int         PTR_W      = 7;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } ljq_cpu_req_t;

    typedef struct packed {
        logic       empty;
        logic       full;
        logic [7:0] level;
    } ljq_fifo_stat_t;
endpackage

// ==== testbench/ljq_top_tb.sv ====
// Self-checking bench for the jitter attenuator and equalizer control block
`timescale 1ns/100ps
module ljq_top_tb;
    import ljq_pkg::*;

    logic           sys_clk_i     = 1'b0;
    logic           reset_i       = 1'b1;
    ljq_cpu_req_t   cpu_req_i     = '0;
    logic [7:0]     cpu_rdata_o;
    logic           ima_mode_i    = 1'b0;
    logic           auto_eq_i     = 1'b0;
    logic           peak_valid_i  = 1'b0;
    logic [7:0]     peak_count_i  = 8'h00;
    logic [3:0]     eq_level_o;
    logic           att_wr_valid_i = 1'b0;
    logic           att_wr_data_i  = 1'b0;
    logic           att_rd_req_i   = 1'b0;
    logic           att_rd_valid_o;
    logic           att_rd_data_o;
    logic           att_center_o;
    ljq_fifo_stat_t att_stat_o;
    int             num_errors    = 0;
    int             n_compared    = 0;
    int             n_center      = 0;
    int             k;
    logic [2:0]     code;

    ljq_top #(.LEVEL_W(4)) dut_u (
        .sys_clk_i     (sys_clk_i),
        .reset_i       (reset_i),
        .cpu_req_i     (cpu_req_i),
        .cpu_rdata_o   (cpu_rdata_o),
        .ima_mode_i    (ima_mode_i),
        .auto_eq_i     (auto_eq_i),
        .peak_valid_i  (peak_valid_i),
        .peak_count_i  (peak_count_i),
        .eq_level_o    (eq_level_o),
        .att_wr_valid_i (att_wr_valid_i),
        .att_wr_data_i  (att_wr_data_i),
        .att_rd_req_i   (att_rd_req_i),
        .att_rd_valid_o (att_rd_valid_o),
        .att_rd_data_o  (att_rd_data_o),
        .att_center_o   (att_center_o),
        .att_stat_o     (att_stat_o)
    );

    always #5 sys_clk_i = ~sys_clk_i;

    // Pulse counting avoids guessing the exact cycle of the centering flag
    always @(posedge sys_clk_i) begin
        if (att_center_o === 1'b1) begin
            n_center <= n_center + 1;
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        cpu_req_i.addr  = a;
        cpu_req_i.wdata = d;
        cpu_req_i.wr    = 1'b1;
        cyc(1);
        cpu_req_i.wr    = 1'b0;
        // Idle edge so a following call never re-raises the strobe at once
        cyc(1);
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp,
                          input string what);
        cpu_req_i.addr = a;
        cpu_req_i.rd   = 1'b1;
        cyc(1);
        cpu_req_i.rd   = 1'b0;
        chk(what, {24'h0, exp}, {24'h0, cpu_rdata_o & m});
        cyc(1);
    endtask

    function automatic logic pat(input int i);
        return i[0] ^ i[3];
    endfunction

    // Pattern bits are indexed from the first push of the call
    task automatic push(input int n, input logic use_pat);
        att_wr_valid_i = 1'b1;
        for (int i = 0; i < n; i++) begin
            att_wr_data_i = use_pat ? pat(i) : 1'b1;
            cyc(1);
        end
        att_wr_valid_i = 1'b0;
        cyc(1);
    endtask

    task automatic pop(input int n, input int first, input logic exp_valid);
        att_rd_req_i = 1'b1;
        for (int i = 0; i < n; i++) begin
            cyc(1);
            chk("rd_valid", {31'h0, exp_valid}, {31'h0, att_rd_valid_o});
            if (exp_valid) begin
                chk("rd_data", {31'h0, pat(first + i)}, {31'h0, att_rd_data_o});
            end
        end
        att_rd_req_i = 1'b0;
        cyc(1);
    endtask

    task automatic st(input logic e, input logic f, input logic [7:0] lvl);
        chk("fifo_stat", {22'h0, e, f, lvl}, {22'h0, att_stat_o});
    endtask

    task automatic peak(input logic [7:0] cnt, input logic [3:0] exp);
        peak_valid_i = 1'b1;
        peak_count_i = cnt;
        cyc(1);
        peak_valid_i = 1'b0;
        chk("eq_level", {28'h0, exp}, {28'h0, eq_level_o});
        cyc(1);
    endtask

    task automatic tally_and_finish;
        $display("Comparisons %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Whole run is near 800 cycles; over twelve times that is clearly a hang
    initial begin
        #100000;
        num_errors++;
        tally_and_finish;
    end

    initial begin
        cyc(3);
        reset_i = 1'b0;
        rd_reg(ADDR_ATT_CTRL, 8'hFF, ATT_CTRL_RST, "ctrl_reset");
        rd_reg(ADDR_EQ_HIGH, 8'hFF, 8'hBB, "upper_reset");
        rd_reg(ADDR_EQ_LOW, 8'hFF, 8'h30, "lower_reset");
        rd_reg(ADDR_ATT_STATUS, 8'hC0, 8'h80, "status_reset");
        rd_reg(8'h14, 8'hFF, 8'h00, "unmapped_read");
        wr_reg(ADDR_EQ_HIGH, 8'h5A);
        wr_reg(8'h15, 8'hFF);
        wr_reg(ADDR_ATT_STATUS, 8'hFF);
        rd_reg(ADDR_EQ_HIGH, 8'hFF, 8'h5A, "upper_rw");
        rd_reg(ADDR_ATT_STATUS, 8'hC0, 8'h80, "status_read_only");
        // Mode off: default depth, control writes have no effect
        push(17, 1'b0);
        st(1'b0, 1'b1, 8'h10);
        wr_reg(ADDR_ATT_CTRL, 8'h7C);
        rd_reg(ADDR_ATT_CTRL, 8'hFF, 8'h00, "ctrl_ignored");
        st(1'b0, 1'b1, 8'h10);
        ima_mode_i = 1'b1;
        for (k = 0; k < 8; k++) begin
            code = 3'((k + 1) % 8);
            wr_reg(ADDR_ATT_CTRL, {2'b00, code, 3'b000});
            st(1'b1, 1'b0, 8'h00);
            push(16 * (code + 1) + 1, 1'b0);
            st(1'b0, 1'b1, 8'(16 * (code + 1)));
        end
        // Depth 32 holding a known pattern; jitter during centering not judged
        wr_reg(ADDR_ATT_CTRL, 8'h08);
        push(32, 1'b1);
        st(1'b0, 1'b1, 8'h20);
        wr_reg(ADDR_ATT_CTRL, 8'h48);
        st(1'b0, 1'b0, 8'h10);
        pop(16, 16, 1'b1);
        pop(1, 0, 1'b0);
        push(3, 1'b0);
        wr_reg(ADDR_ATT_CTRL, 8'h4C);
        st(1'b1, 1'b0, 8'h00);
        rd_reg(ADDR_ATT_CTRL, 8'hFF, 8'h4C, "ctrl_readback");
        rd_reg(ADDR_ATT_STATUS, 8'hC0, 8'h80, "status_after_clear");
        pop(1, 0, 1'b0);
        // Falling toggle exposes old bits that the clear left in place
        wr_reg(ADDR_ATT_CTRL, 8'h08);
        st(1'b0, 1'b0, 8'h10);
        pop(16, 16, 1'b1);
        cyc(2);
        chk("center_pulses", 32'h2, n_center);
        // Equalizer stepping
        wr_reg(ADDR_EQ_HIGH, 8'hBB);
        peak(8'h00, 4'h0);
        auto_eq_i = 1'b1;
        peak(8'h2F, 4'h1);
        peak(8'h30, 4'h1);
        peak(8'hBB, 4'h1);
        peak(8'hBC, 4'h0);
        peak(8'hFF, 4'h0);
        for (k = 0; k < 16; k++) begin
            peak(8'h00, 4'((k < 15) ? k + 1 : 15));
        end
        peak(8'hC0, 4'hE);
        auto_eq_i = 1'b0;
        peak(8'h00, 4'hE);
        peak(8'hFF, 4'hE);
        wr_reg(ADDR_EQ_LOW, 8'h80);
        auto_eq_i = 1'b1;
        peak(8'h7F, 4'hF);
        tally_and_finish;
    end
endmodule // ljq_top_tb
